// file: rtl/ssbe_cfg.svh
// constants of the serial channel baud-rate and error block
// assumes: included by bare name from every design file that needs it
`ifndef SSBE_CFG_SVH
`define SSBE_CFG_SVH

// ****************************************
// register map
// ****************************************
`define SSBE_REG_BAUD      16'hE80A
`define SSBE_BAUD_RST      16'h0000

// ****************************************
// timing and sizes
// ****************************************
`define SSBE_CLK_PERIOD_NS 5
`define SSBE_TMR_DIV       2
`define SSBE_DATA_W        16
`define SSBE_FIFO_DEPTH    8
`define SSBE_PH_AFTER      2'h2
`define SSBE_PER_MAX       20'hFFFFF

// ****************************************
// error flag positions
// ****************************************
`define SSBE_ERR_RX        0
`define SSBE_ERR_PH        1
`define SSBE_ERR_RATE      2
`define SSBE_ERR_TX        3
`define SSBE_ERR_N         4

`endif

// file: rtl/ssbe_fifo.sv
// synchronous FIFO for received frames, valid and ready on both sides
// assumes: one clock; the drain side may stall at will
`timescale 1ns/100ps
module ssbe_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 8
) (
   // clock and reset
   input  wire logic             core_clk,
   input  wire logic             rst,
   // fill side
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   // drain side
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);

   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr_ff;
   logic [AW-1:0]    rd_ptr_ff;
   logic [AW:0]      count_ff;
   logic             in_ready_ff;
   logic             out_valid_ff;

   // handshakes and next occupancy
   wire          push      = in_valid && in_ready_ff;
   wire          pop       = out_valid_ff && out_ready;
   wire [AW:0]   nxt_count = count_ff + (AW+1)'(push) - (AW+1)'(pop);

   // flags are registered from the next count so they are never stale
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         wr_ptr_ff    <= '0;
         rd_ptr_ff    <= '0;
         count_ff     <= '0;
         in_ready_ff  <= 1'b1;
         out_valid_ff <= 1'b0;
      end else begin
         wr_ptr_ff    <= push ? AW'(wr_ptr_ff + 1'b1) : wr_ptr_ff;
         rd_ptr_ff    <= pop ? AW'(rd_ptr_ff + 1'b1) : rd_ptr_ff;
         count_ff     <= nxt_count;
         in_ready_ff  <= nxt_count != (AW+1)'(DEPTH);
         out_valid_ff <= nxt_count != '0;
      end
   end

   // storage has no reset, only written entries are ever read
   always_ff @(posedge core_clk) begin
      if (push) begin
         mem[wr_ptr_ff] <= in_data;
      end
   end

   assign in_ready  = in_ready_ff;
   assign out_valid = out_valid_ff;
   assign out_data  = mem[rd_ptr_ff];

endmodule

// file: rtl/ssbe_pkg.sv
// types shared by the serial channel baud-rate and error block
// assumes: compiled before every module of the block
package ssbe_pkg;

   // ****************************************
   // interrupt vector selection
   // ****************************************
   typedef enum logic [1:0] {
      SSBE_VEC_A   = 2'h0,
      SSBE_VEC_B   = 2'h1,
      SSBE_VEC_C   = 2'h2,
      SSBE_VEC_OFF = 2'h3
   } ssbe_vec_t;

endpackage

// file: rtl/ssbe_sync.sv
// three-stage pin synchroniser with agreement filter
// assumes: inputs are asynchronous pins, core_clk domain on the output
`timescale 1ns/100ps
module ssbe_sync #(
   parameter int WIDTH = 1
) (
   // clock and reset
   input  wire logic             core_clk,
   input  wire logic             rst,
   // pins and filtered result
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] s1_ff;
   logic [WIDTH-1:0] s2_ff;
   logic [WIDTH-1:0] s3_ff;
   logic [WIDTH-1:0] out_ff;

   // a change counts once stages two and three agree, so one late stage cannot glitch it
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         s1_ff  <= '0;
         s2_ff  <= '0;
         s3_ff  <= '0;
         out_ff <= '0;
      end else begin
         s1_ff  <= async_in;
         s2_ff  <= s1_ff;
         s3_ff  <= s2_ff;
         out_ff <= (s2_ff & s3_ff) | (out_ff & (s2_ff ^ s3_ff));
      end
   end

   assign sync_out = out_ff;

endmodule

// file: rtl/ssbe_top.sv
// serial channel baud-rate timer, error detectors, flags and interrupt routing
// assumes: a shift engine beside it supplies frames and transfer events,
// software control bits arrive as plain levels, pins are asynchronous
//
// Behaviour
// R1: own 16-bit down timer with 16-bit reload, separate from general timers.
// R2: timer advances once every two core clocks.
// R3: timer counts down while channel_enable is 1, stops while 0.
// R4: reading the reload register while enabled returns the running count.
// R5: while disabled, reads return reload value and writes load it.
// R6: software never writes the reload register while the channel is enabled.
// R7: bit rate is core clock over two times reload plus one.
// R8: at zero the timer reloads and emits one tick per period.
// R9: overrun and phase errors in both modes, underrun and rate only slave.
// R10: every error sets its flag; error interrupt only if its enable set.
// R11: error flags stay set until software clears them.
// R12: error handler clears serviced enabled flags or interrupt stays raised.
// R13: frame arriving over unread receive_buffer sets overrun, overwrites buffer.
// R14: data sampled each clock; change near latching edge sets phase_error_flag.
// R15: slave shift clock faster than double or below half rate sets rate_error_flag.
// R16: slave timer must be programmed to the master's bit rate.
// R17: rate error with auto_reset_enable resets and reinitialises the channel.
// R18: slave transfer start without fresh transmit_buffer sets tx_underrun_flag.
// R19: on underrun the slave shifts out stale shift-register contents.
// R20: unselected open-drain slaves load transmit_buffer with all ones.
// R21: software should load the slave transmit_buffer before every transfer.
// R22: receive, transmit, error lines; first two selectable, error fixed vector.
// R23: each finished transfer fills receive_buffer and sets rx_irq_flag.
`timescale 1ns/100ps
`include "ssbe_cfg.svh"
module ssbe_top (
   // clock and reset
   input  wire logic                    core_clk,
   input  wire logic                    rst,
   // reload register port
   input  wire logic [15:0]             reg_addr,
   input  wire logic                    reg_rd,
   input  wire logic                    reg_wr,
   input  wire logic [15:0]             reg_wdata,
   output logic      [15:0]             reg_rdata,
   // serial_control levels from software
   input  wire logic                    channel_enable,
   input  wire logic                    slave_mode,
   input  wire logic                    latch_on_rise,
   input  wire logic                    auto_reset_enable,
   input  wire logic [`SSBE_ERR_N-1:0]  err_irq_en,
   input  wire logic [`SSBE_ERR_N-1:0]  err_clr,
   input  wire logic                    rx_irq_clr,
   input  wire ssbe_pkg::ssbe_vec_t     rx_irq_sel,
   input  wire ssbe_pkg::ssbe_vec_t     tx_irq_sel,
   // serial pins, inputs only
   input  wire logic                    shift_clock_line,
   input  wire logic                    master_in_slave_out_line,
   input  wire logic                    master_out_slave_in_line,
   // shift engine side
   input  wire logic                    frame_valid,
   output logic                         frame_ready,
   input  wire logic [`SSBE_DATA_W-1:0] frame_data,
   input  wire logic                    xfer_start,
   input  wire logic                    xfer_active,
   input  wire logic                    tb_write,
   input  wire logic                    rb_read,
   input  wire logic                    tx_irq_req,
   output logic                         baud_tick,
   output logic                         tx_stale,
   output logic                         channel_reset,
   // status and receive data
   output logic      [`SSBE_DATA_W-1:0] receive_buffer,
   output logic      [`SSBE_ERR_N-1:0]  err_flags,
   output logic                         rx_irq_flag,
   // interrupt vectors
   output logic                         shared_irq_vector_a,
   output logic                         shared_irq_vector_b,
   output logic                         shared_irq_vector_c,
   output logic                         error_irq_vector
);
   import ssbe_pkg::*;

   // ****************************************
   // baud-rate timer
   // ****************************************
   logic        div_ff;
   logic [15:0] reload_ff;
   logic [15:0] cnt_ff;
   logic        tick_ff;
   logic [15:0] rdata_ff;
   logic        rst_ch_ff;

   wire        reg_hit   = reg_addr == `SSBE_REG_BAUD;
   wire        tmr_en    = div_ff;                                   // [R2]
   wire        run       = channel_enable && !rst_ch_ff;             // [R3]
   wire        cnt_zero  = cnt_ff == 16'h0000;
   wire        reload_we = reg_wr && reg_hit && !channel_enable;    // [R5] [R6]
   // reload at zero gives reload+1 timer clocks per tick [R7] [R8]
   wire [15:0] nxt_cnt   = !run ? reload_ff :
                           !tmr_en ? cnt_ff :
                           cnt_zero ? reload_ff : cnt_ff - 16'h0001;
   wire        nxt_tick  = run && tmr_en && cnt_zero;                // [R8]
   // read returns the count when enabled, else the reload value [R4] [R5]
   wire [15:0] nxt_rdata = !(reg_rd && reg_hit) ? 16'h0000 :
                           channel_enable ? cnt_ff : reload_ff;

   // divider runs free so that the timer rate does not depend on enable timing
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         div_ff    <= 1'b0;
         reload_ff <= `SSBE_BAUD_RST;
         cnt_ff    <= `SSBE_BAUD_RST;
         tick_ff   <= 1'b0;
         rdata_ff  <= 16'h0000;
      end else begin
         div_ff    <= ~div_ff;
         reload_ff <= reload_we ? reg_wdata : reload_ff;             // [R1]
         cnt_ff    <= nxt_cnt;                                       // [R1] [R3]
         tick_ff   <= nxt_tick;
         rdata_ff  <= nxt_rdata;
      end
   end

   // ****************************************
   // pin sampling and latching edge
   // ****************************************
   logic [2:0] pin_s;
   logic       sclk_prev_ff;
   logic       din_prev_ff;
   logic       ref_ff;
   logic [1:0] win_ff;

   ssbe_sync #(.WIDTH(3)) u_sync (
      .core_clk (core_clk),
      .rst      (rst),
      .async_in ({shift_clock_line, master_in_slave_out_line, master_out_slave_in_line}),
      .sync_out (pin_s)
   );

   // data input follows the mode: master listens on the slave-out line
   wire sclk_s     = pin_s[2];
   wire din_s      = slave_mode ? pin_s[0] : pin_s[1];
   wire latch_edge = (sclk_s != sclk_prev_ff) && (sclk_s == latch_on_rise);
   // window: one sample before the edge against the edge and two after [R14]
   wire ph_hit     = channel_enable &&
                     ((latch_edge && din_s != din_prev_ff) ||
                      (win_ff != 2'h0 && din_s != ref_ff));          // [R9]
   wire [1:0] nxt_win = latch_edge ? `SSBE_PH_AFTER :
                        win_ff != 2'h0 ? win_ff - 2'h1 : 2'h0;

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         sclk_prev_ff <= 1'b0;
         din_prev_ff  <= 1'b0;
         ref_ff       <= 1'b0;
         win_ff       <= 2'h0;
      end else begin
         sclk_prev_ff <= sclk_s;
         din_prev_ff  <= din_s;
         ref_ff       <= latch_edge ? din_prev_ff : ref_ff;
         win_ff       <= nxt_win;
      end
   end

   // ****************************************
   // shift clock rate check, slave only
   // ****************************************
   logic [19:0] per_ff;
   logic        seen_ff;

   // expected period is 2*(reload+1); half of it and double of it bound the window
   wire        meas    = channel_enable && slave_mode && xfer_active && !rst_ch_ff;
   wire [19:0] per_lo  = {4'h0, reload_ff} + 20'h00001;
   wire [19:0] per_hi  = {per_lo[17:0], 2'b00};
   // a missing pulse shows as the count passing the slow bound once
   wire        rate_hit = meas && seen_ff &&
                          ((latch_edge && (per_ff < per_lo || per_ff > per_hi)) ||
                           (!latch_edge && per_ff == per_hi + 20'h00001)); // [R15] [R9]
   wire [19:0] nxt_per = !meas ? 20'h00000 :
                         latch_edge ? 20'h00001 :
                         per_ff == `SSBE_PER_MAX ? per_ff : per_ff + 20'h00001;

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         per_ff  <= 20'h00000;
         seen_ff <= 1'b0;
      end else begin
         per_ff  <= nxt_per;
         seen_ff <= meas && (seen_ff || latch_edge);
      end
   end

   // ****************************************
   // transmit underrun, slave only
   // ****************************************
   logic tb_written_ff;
   logic stale_ff;

   wire un_hit = channel_enable && slave_mode && xfer_start && !tb_written_ff; // [R18] [R9]

   // a write in the start cycle still counts as fresh data for the next transfer
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         tb_written_ff <= 1'b0;
         stale_ff      <= 1'b0;
      end else begin
         tb_written_ff <= tb_write || (tb_written_ff && !xfer_start);
         stale_ff      <= un_hit;                                    // [R19]
      end
   end

   // ****************************************
   // receive path through the frame FIFO
   // ****************************************
   logic                    f_valid;
   logic [`SSBE_DATA_W-1:0] f_data;
   logic [`SSBE_DATA_W-1:0] rxbuf_ff;
   logic                    unread_ff;
   logic                    rxirq_ff;

   // draining stalls while disabled, so the FIFO can fill and push back
   wire f_pop  = f_valid && channel_enable;
   wire ovr_hit = f_pop && unread_ff && !rb_read;                    // [R13] [R9]

   ssbe_fifo #(.WIDTH(`SSBE_DATA_W), .DEPTH(`SSBE_FIFO_DEPTH)) u_fifo (
      .core_clk  (core_clk),
      .rst       (rst),
      .in_valid  (frame_valid),
      .in_ready  (frame_ready),
      .in_data   (frame_data),
      .out_valid (f_valid),
      .out_ready (channel_enable),
      .out_data  (f_data)
   );

   // a new frame always overwrites, the old word is lost on overrun
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         rxbuf_ff  <= '0;
         unread_ff <= 1'b0;
         rxirq_ff  <= 1'b0;
      end else begin
         rxbuf_ff  <= f_pop ? f_data : rxbuf_ff;                     // [R23] [R13]
         unread_ff <= f_pop || (unread_ff && !rb_read);
         rxirq_ff  <= f_pop || (rxirq_ff && !rx_irq_clr);            // [R23]
      end
   end

   // ****************************************
   // error flags, auto reset, interrupt lines
   // ****************************************
   logic [`SSBE_ERR_N-1:0] err_ff;
   logic                   errirq_ff;
   logic [2:0]             vec_ff;
   logic [`SSBE_ERR_N-1:0] err_set;
   logic [2:0]             nxt_vec;

   assign err_set[`SSBE_ERR_RX]   = ovr_hit;
   assign err_set[`SSBE_ERR_PH]   = ph_hit;
   assign err_set[`SSBE_ERR_RATE] = rate_hit;
   assign err_set[`SSBE_ERR_TX]   = un_hit;

   // set beats clear; nothing but err_clr removes a flag [R10] [R11]
   wire [`SSBE_ERR_N-1:0] nxt_err = (err_ff & ~err_clr) | err_set;
   // level request keeps asking while an enabled flag stays set [R10] [R12]
   wire nxt_errirq = |(nxt_err & err_irq_en);

   // receive and transmit share three vectors by selection [R22]
   genvar gv;
   generate
      for (gv = 0; gv < 3; gv++) begin : g_vec
         assign nxt_vec[gv] = (rxirq_ff && rx_irq_sel == ssbe_vec_t'(2'(gv))) ||
                              (tx_irq_req && tx_irq_sel == ssbe_vec_t'(2'(gv)));
      end
   endgenerate

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         err_ff    <= '0;
         errirq_ff <= 1'b0;
         vec_ff    <= 3'h0;
         rst_ch_ff <= 1'b0;
      end else begin
         err_ff    <= nxt_err;
         errirq_ff <= nxt_errirq;                                    // [R22]
         vec_ff    <= nxt_vec;
         rst_ch_ff <= rate_hit && auto_reset_enable;                 // [R17]
      end
   end

   assign reg_rdata           = rdata_ff;
   assign baud_tick           = tick_ff;
   assign tx_stale            = stale_ff;
   assign channel_reset       = rst_ch_ff;
   assign receive_buffer      = rxbuf_ff;
   assign err_flags           = err_ff;
   assign rx_irq_flag         = rxirq_ff;
   assign shared_irq_vector_a = vec_ff[0];
   assign shared_irq_vector_b = vec_ff[1];
   assign shared_irq_vector_c = vec_ff[2];
   assign error_irq_vector    = errirq_ff;

   // ****************************************
   // assertions
   // ****************************************
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);

   logic [17:0] gap_ff;
   logic        gap_ok_ff;

   // tick spacing helper, valid only across an unbroken run
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         gap_ff    <= 18'h00000;
         gap_ok_ff <= 1'b0;
      end else begin
         gap_ff    <= tick_ff ? 18'h00001 : gap_ff + 18'h00001;
         gap_ok_ff <= run && (gap_ok_ff || tick_ff);
      end
   end

   AST_TICK_PERIOD: assert property (tick_ff && gap_ok_ff && run |-> // [R7]
      gap_ff == {1'b0, reload_ff, 1'b0} + 18'h00002)
      else $error("baud tick spacing wrong");
   AST_DIV_RATE: assert property (tmr_en |=> !tmr_en ##1 tmr_en) // [R2]
      else $error("timer enable not every second clock");
   AST_STOPPED: assert property (!channel_enable |=> // [R3]
      !tick_ff && cnt_ff == $past(reload_ff))
      else $error("timer runs while disabled");
   AST_READ_COUNT: assert property (reg_rd && reg_hit && channel_enable |=> // [R4]
      reg_rdata == $past(cnt_ff))
      else $error("enabled read not the count");
   AST_READ_RELOAD: assert property (reg_rd && reg_hit && !channel_enable |=> // [R5]
      reg_rdata == $past(reload_ff))
      else $error("disabled read not the reload");
   AST_NO_WR_EN: assert property (channel_enable && reg_wr |=> $stable(reload_ff)) // [R6]
      else $error("reload changed while enabled");
   AST_STICKY: assert property (1'b1 |=> // [R11]
      ((err_ff & $past(err_ff & ~err_clr)) == $past(err_ff & ~err_clr)))
      else $error("error flag lost without clear");
   AST_ERR_IRQ: assert property (error_irq_vector == |(err_ff & $past(err_irq_en))) // [R10]
      else $error("error request not tied to enabled flags");
   AST_OVERRUN: assert property (f_pop && unread_ff && !rb_read |=> // [R13]
      err_ff[`SSBE_ERR_RX] && rx_irq_flag && receive_buffer == $past(f_data))
      else $error("overrun not flagged");
   AST_UNDERRUN: assert property (un_hit |=> err_ff[`SSBE_ERR_TX] && tx_stale) // [R18]
      else $error("underrun not flagged");
   AST_MASTER_NO_SLAVE_ERR: assert property (!slave_mode && $past(!slave_mode) |-> // [R9]
      !$rose(err_ff[`SSBE_ERR_RATE]) && !$rose(err_ff[`SSBE_ERR_TX]))
      else $error("slave-only error in master mode");
   AST_AUTO_RESET: assert property (rate_hit && auto_reset_enable |=> // [R17]
      channel_reset ##1 cnt_ff == reload_ff)
      else $error("auto reset missing");

   COV_TICK: cover property (tick_ff && gap_ok_ff);
   COV_OVERRUN: cover property (ovr_hit);
   COV_RATE: cover property (rate_hit && auto_reset_enable);
   COV_PHASE: cover property (ph_hit ##1 error_irq_vector);

endmodule

// file: test/ssbe_far_model.sv
// far-end serial master model: drives the shift clock and both data pins
// assumes: bench clock; run is high only inside a frame
`timescale 1ns/100ps
module ssbe_far_model (
   // clock and control
   input  wire logic        core_clk,
   input  wire logic        run,
   input  wire logic [15:0] half,
   // serial pins
   output logic             sclk,
   output logic             mosi,
   output logic             miso
);
   int cnt;
   initial begin
      cnt = 0;
      {sclk, mosi, miso} = 3'h2;
   end
   // clock stands still between frames; half period in core clocks comes from the half input
   always @(posedge core_clk) begin
      cnt <= (!run || cnt + 1 >= half) ? 0 : cnt + 1;
      sclk <= run ? (cnt + 1 >= half ? !sclk : sclk) : 1'b0;
      // idle: no pull on the data lines, so never hold a stale level
      // in a frame data moves on the clock edge itself, a late master
      mosi <= (!run || cnt + 1 >= half) ? !mosi : mosi;
      miso <= (!run || cnt + 1 >= half) ? !miso : miso;
   end
endmodule

// file: test/testbench.sv
// self-checking bench for the baud-rate and error block
// assumes: far model on the pins, bench drives all other inputs at falling edges
`timescale 1ns/100ps
`include "ssbe_cfg.svh"
module testbench;
   import ssbe_pkg::*;
   logic        core_clk, rst, reg_rd, reg_wr, channel_enable, slave_mode, latch_on_rise;
   logic        auto_reset_enable, rx_irq_clr, frame_valid, frame_ready, xfer_start;
   logic        xfer_active, tb_write, rb_read, tx_irq_req, baud_tick, tx_stale;
   logic        channel_reset, rx_irq_flag, shared_irq_vector_a, shared_irq_vector_b;
   logic        shared_irq_vector_c, error_irq_vector, run, rd_seen, seen;
   logic        shift_clock_line, master_in_slave_out_line, master_out_slave_in_line;
   logic [15:0] reg_addr, reg_wdata, reg_rdata, frame_data, receive_buffer, half, rl, last;
   logic [3:0]  err_irq_en, err_clr, err_flags;
   ssbe_vec_t   rx_irq_sel, tx_irq_sel;
   logic [15:0] exp_q[$];
   int          checks, n_mismatch, cyc, seed, n, v;

   ssbe_top u_dut (.core_clk, .rst, .reg_addr, .reg_rd, .reg_wr, .reg_wdata, .reg_rdata,
      .channel_enable, .slave_mode, .latch_on_rise, .auto_reset_enable, .err_irq_en,
      .err_clr, .rx_irq_clr, .rx_irq_sel, .tx_irq_sel, .shift_clock_line,
      .master_in_slave_out_line, .master_out_slave_in_line, .frame_valid, .frame_ready,
      .frame_data, .xfer_start, .xfer_active, .tb_write, .rb_read, .tx_irq_req, .baud_tick,
      .tx_stale, .channel_reset, .receive_buffer, .err_flags, .rx_irq_flag,
      .shared_irq_vector_a, .shared_irq_vector_b, .shared_irq_vector_c, .error_irq_vector);
   ssbe_far_model u_far (.core_clk, .run, .half, .sclk(shift_clock_line),
      .mosi(master_out_slave_in_line), .miso(master_in_slave_out_line));

   // ****************************************
   // clock, timeout, checking
   // ****************************************
   initial begin
      core_clk = 0;
      forever #2.5 core_clk = ~core_clk;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // ceiling well above the few hundred cycles the run needs
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 20000) begin
         n_mismatch++;
         conclude();
      end
   end
   // read data stands one cycle after the strobe; oldest note is compared mid-cycle
   always @(posedge core_clk) rd_seen <= reg_rd;
   always @(negedge core_clk) if (rd_seen) chk(reg_rdata, exp_q.pop_front());
   task automatic wr(input logic [15:0] a, input logic [15:0] d);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1;
      @(negedge core_clk) reg_wr = 0;
   endtask
   task automatic rd(input logic [15:0] a, input logic [15:0] e);
      reg_addr = a;
      reg_rd = 1;
      exp_q.push_back(e);
      @(negedge core_clk) reg_rd = 0;
      @(negedge core_clk);
   endtask
   task automatic pulse_start(input logic e);
      xfer_start = 1;
      @(negedge core_clk) xfer_start = 0;
      chk(tx_stale, e);
      repeat (4) @(negedge core_clk);
   endtask

   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      {checks, n_mismatch, cyc, rd_seen, seed, rst} = {32'h0, 32'h0, 32'h0, 1'b0, 32'h36, 1'b1};
      {reg_rd, reg_wr, channel_enable, slave_mode, latch_on_rise, auto_reset_enable} = '0;
      {rx_irq_clr, frame_valid, xfer_start, xfer_active, tb_write, rb_read, tx_irq_req} = '0;
      {reg_addr, reg_wdata, frame_data, err_irq_en, err_clr, run} = '0;
      rx_irq_sel = SSBE_VEC_OFF;
      tx_irq_sel = SSBE_VEC_OFF;
      half = 16'h0002;
      repeat (12) @(negedge core_clk);
      rst = 0;
      @(negedge core_clk);
      rd(`SSBE_REG_BAUD, `SSBE_BAUD_RST);
      rl = 16'h0004 + (16'($random(seed)) & 16'h0007);
      wr(`SSBE_REG_BAUD, rl);
      rd(`SSBE_REG_BAUD, rl);
      rd(16'hE80C, 16'h0000);
      // bit period is two core clocks per timer step, reload plus one steps
      channel_enable = 1;
      for (n = 0; baud_tick !== 1'b1 && n < 1000; n++) @(negedge core_clk);
      @(negedge core_clk);
      for (n = 1; baud_tick !== 1'b1 && n < 1000; n++) @(negedge core_clk);
      chk(n, 2 * (rl + 1));
      wr(`SSBE_REG_BAUD, ~rl);
      channel_enable = 0;
      rd(`SSBE_REG_BAUD, rl);
      // fill the buffer to its depth while disabled, check it refuses more, then drain
      for (n = 0; n < 8; n++) begin
         frame_valid = 1;
         frame_data = 16'($random(seed));
         last = frame_data;
         @(negedge core_clk);
      end
      frame_valid = 0;
      @(negedge core_clk);
      chk(frame_ready, 0);
      channel_enable = 1;
      repeat (14) @(negedge core_clk);
      chk(receive_buffer, last);
      chk(err_flags, 4'h1);
      chk(rx_irq_flag, 1);
      chk(error_irq_vector, 0);
      tx_irq_req = 1;
      for (v = 0; v < 3; v++) begin
         rx_irq_sel = ssbe_vec_t'(v);
         tx_irq_sel = ssbe_vec_t'((v + 1) % 3);
         repeat (3) @(negedge core_clk);
         chk({shared_irq_vector_c, shared_irq_vector_b, shared_irq_vector_a},
             (1 << v) | (1 << ((v + 1) % 3)));
      end
      {tx_irq_req, rx_irq_clr, err_clr} = 6'h1F;
      @(negedge core_clk) {rx_irq_clr, err_clr} = '0;
      repeat (3) @(negedge core_clk);
      chk({rx_irq_flag, err_flags, shared_irq_vector_a, shared_irq_vector_b}, 0);
      // underrun in slave mode, then a fresh write avoids it
      {slave_mode, err_irq_en} = 5'h18;
      pulse_start(1'b1);
      repeat (4) @(negedge core_clk);
      chk({err_flags[3], error_irq_vector}, 2'h3);
      {err_clr, tb_write} = 5'h11;
      @(negedge core_clk) {err_clr, tb_write} = '0;
      pulse_start(1'b0);
      chk({err_flags[3], error_irq_vector}, 0);
      slave_mode = 0;
      pulse_start(1'b0);
      pulse_start(1'b0);
      chk(err_flags[3], 0);
      // shift clock far faster than double the programmed rate, data on the latching edge
      {slave_mode, auto_reset_enable, err_irq_en, xfer_active, run, seen} = 9'h1AE;
      for (n = 0; n < 200; n++) @(negedge core_clk) seen |= (channel_reset === 1'b1);
      {run, xfer_active} = '0;
      chk({err_flags[2:1], error_irq_vector, seen}, 4'hF);
      conclude();
   end
endmodule
